/* src/obs_probe_pkg.sv */
package obs_probe_pkg;
    // Register byte offsets on the plain register port.
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_F0_BASE   = 8'h04;
    localparam logic [7:0]  OFS_F0_MASK   = 8'h08;
    localparam logic [7:0]  OFS_F0_BLOCK  = 8'h0c;
    localparam logic [7:0]  OFS_F1_BASE   = 8'h10;
    localparam logic [7:0]  OFS_F1_MASK   = 8'h14;
    localparam logic [7:0]  OFS_F1_BLOCK  = 8'h18;
    localparam logic [7:0]  OFS_STAT_SEL  = 8'h1c;
    localparam logic [7:0]  OFS_STAT_CNT  = 8'h20;
    localparam logic [7:0]  OFS_STAT_LVL  = 8'h30;
    localparam logic [7:0]  OFS_THR       = 8'h40;
    localparam logic [7:0]  OFS_HIST      = 8'h44;
    localparam logic [7:0]  OFS_INT_STAT  = 8'h54;
    localparam logic [7:0]  OFS_INT_MASK  = 8'h58;
    localparam logic [7:0]  OFS_INFO      = 8'h5c;
    // Control register bit positions.
    localparam int CTRL_F0_EN    = 0;
    localparam int CTRL_F0_ALARM = 2;
    localparam int CTRL_COMBINE  = 4;
    localparam int CTRL_TRACE_EN = 5;
    localparam int CTRL_PEND     = 6;
    localparam int CTRL_CLEAR    = 7;
    localparam int CTRL_W        = 7;
    // Interrupt status bit positions.
    localparam int INT_TRACE = 0;
    localparam int INT_STAT  = 2;
    localparam int INT_ERR   = 6;
    localparam int INT_W     = 9;
    // Every register except the info register resets to zero.
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    // Probe identifiers on the trace bus.
    localparam logic [3:0] ID_COHERENCY = 4'h3;
    localparam logic [3:0] ID_BRIDGE    = 4'h2;
    localparam logic [3:0] ID_ETH       = 4'h1;
    // Probe shape.
    localparam int FILTER_COUNT       = 2;
    localparam int STAT_COUNTER_COUNT = 4;
    localparam int STAT_COUNTER_WIDTH = 16;
    localparam int HIST_W             = 10;
    localparam int CMP_N              = 3;
    // Comparator threshold tables, selected by a 2-bit index.
    localparam logic [3:0][9:0] LAT_THR  =
        {10'd512, 10'd256, 10'd128, 10'd64};
    localparam logic [3:0][9:0] PEND_THR =
        {10'd8, 10'd8, 10'd4, 10'd2};
endpackage

/* src/stat_bank_if.sv */
`timescale 1ns/1ps
interface stat_bank_if #(
    parameter int N = 4,
    parameter int W = 16
);
    logic [N-1:0]        inc;
    logic                clr;
    logic [N-1:0][W-1:0] level;
    logic [N-1:0][W-1:0] count;
    logic [N-1:0]        hit;
    modport ctl  (output inc, clr, level, input count, hit);
    modport bank (input inc, clr, level, output count, hit);
endinterface

/* src/sat_counter_bank.sv */
`timescale 1ns/1ps
module sat_counter_bank #(
    parameter int N = 4,
    parameter int W = 16
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    stat_bank_if.bank       sb
);
    typedef struct packed {
        logic [N-1:0][W-1:0] cnt;
        logic [N-1:0]        hit;
    } bank_s;
    bank_s q;
    bank_s d;

    // Saturating count and a one-cycle pulse on reaching the level.
    always_comb begin
        d = q;
        for (int i = 0; i < N; i++) begin
            d.hit[i] = 1'b0;
            if (sb.clr) begin
                d.cnt[i] = '0;
            end else if (sb.inc[i] && q.cnt[i] != '1) begin // R04
                d.cnt[i] = q.cnt[i] + W'(1); // R14
            end
            if (sb.level[i] != '0 && d.cnt[i] == sb.level[i]
                && q.cnt[i] != sb.level[i]) begin
                d.hit[i] = 1'b1; // R05
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sb.count = q.cnt;
    assign sb.hit   = q.hit;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    AST_CNT_SAT: assert property ( // R14
        !sb.clr && sb.inc[0] && q.cnt[0] == '1 |=> q.cnt[0] == '1)
        else $error("Counter wrapped past its maximum.");
    AST_CNT_INC: assert property ( // R04
        !sb.clr && sb.inc[0] && q.cnt[0] != '1
        |=> q.cnt[0] == $past(q.cnt[0]) + W'(1))
        else $error("Counter did not advance by one.");
endmodule

/* src/interconnect_observation_probes.sv */
`timescale 1ns/1ps
// Function
// R01 - Packets matching the filters are forwarded to the trace output.
// R02 - Two filters work alone or together and ignore byte enables/payload.
// R03 - A hit on an alarm-enabled filter sets a readable trace alarm.
// R04 - Four 16-bit counters count packets meeting their chosen criteria.
// R05 - A counter reaching its programmed level raises a statistics alarm.
// R06 - Trace output carries the probe identifier (3, 2 or 1).
// R07 - The transaction probe builds a histogram in latency or pending mode.
// R08 - Three comparators feed 10-bit histogram counters.
// R09 - In latency mode each comparator takes 64, 128, 256 or 512 cycles.
// R10 - Latency counts cycles from request issue to response return.
// R11 - In pending mode each comparator takes 2, 4 or 8 outstanding requests.
// R12 - Trace and statistics alarms can raise an interrupt.
// R13 - Initiator, target and firewall errors are recorded.
// R14 - Statistics counters saturate instead of wrapping.
module interconnect_observation_probes #(
    parameter logic [3:0] PROBE_ID = obs_probe_pkg::ID_COHERENCY
) (
    input  wire logic                             core_clk_i,
    input  wire logic                             rst_i,
    input  wire logic [obs_probe_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                      reg_wdata_i,
    input  wire logic                             reg_wr_i,
    input  wire logic                             reg_rd_i,
    output logic      [31:0]                      reg_rdata_o,
    input  wire logic                             pkt_valid_i,
    input  wire logic [31:0]                      pkt_addr_i,
    input  wire logic [3:0]                       pkt_opc_i,
    input  wire logic                             pkt_err_i,
    input  wire logic                             txn_req_i,
    input  wire logic                             txn_resp_i,
    input  wire logic                             err_initiator_i,
    input  wire logic                             err_target_i,
    input  wire logic                             err_firewall_i,
    output logic                                  trace_valid_o,
    output logic      [31:0]                      trace_addr_o,
    output logic      [3:0]                       trace_opc_o,
    output logic      [3:0]                       trace_id_o,
    output logic                                  irq_o
);
    import obs_probe_pkg::*;

    localparam int NF = FILTER_COUNT;
    localparam int NS = STAT_COUNTER_COUNT;
    localparam int SW = STAT_COUNTER_WIDTH;

    typedef struct packed {
        logic [CTRL_W-1:0]          ctrl;
        logic [NF-1:0][31:0]        f_base;
        logic [NF-1:0][31:0]        f_mask;
        logic [NF-1:0][15:0]        f_block;
        logic [NS-1:0][3:0]         stat_sel;
        logic [NS-1:0][SW-1:0]      stat_lvl;
        logic [11:0]                thr;
        logic [CMP_N:0][HIST_W-1:0] hist;
        logic [INT_W-1:0]           int_st;
        logic [INT_W-1:0]           int_msk;
        logic [31:0]                rdata;
        logic                       irq;
        logic                       tr_valid;
        logic [31:0]                tr_addr;
        logic [3:0]                 tr_opc;
        logic [3:0]                 tr_id;
        logic                       stat_clr;
        logic                       busy;
        logic [HIST_W-1:0]          lat;
        logic [3:0]                 pend;
    } probe_s;

    probe_s q;
    probe_s d;

    stat_bank_if #(.N(NS), .W(SW)) sb ();

    logic [NF-1:0]                f_hit;
    logic                         match;
    logic [3:0]                   crit;
    logic [CMP_N-1:0][HIST_W-1:0] lat_thr;
    logic [CMP_N-1:0][HIST_W-1:0] pend_thr;
    logic [HIST_W-1:0]            lat_now;
    logic [31:0]                  rd_val;
    logic                         wr_ctrl;

    // Saturating increment of a histogram-width value.
    function automatic logic [HIST_W-1:0] sat_inc(
        input logic [HIST_W-1:0] v);
        return (v == '1) ? v : v + HIST_W'(1);
    endfunction

    // Number of comparator thresholds that a value reaches.
    function automatic logic [1:0] bin_of(
        input logic [HIST_W-1:0]            v,
        input logic [CMP_N-1:0][HIST_W-1:0] t);
        logic [1:0] n;
        n = 2'd0;
        for (int i = 0; i < CMP_N; i++) begin
            if (v >= t[i]) begin
                n = n + 2'd1;
            end
        end
        return n;
    endfunction

    // Filter match on address window and opcode; byte enables unused.
    always_comb begin
        for (int k = 0; k < NF; k++) begin
            f_hit[k] = q.ctrl[CTRL_F0_EN + k]
                && ((pkt_addr_i ^ q.f_base[k]) & q.f_mask[k]) == '0
                && !q.f_block[k][pkt_opc_i]; // R02
        end
        if (q.ctrl[CTRL_COMBINE]) begin
            match = (q.ctrl[1:0] != '0)
                && (f_hit == q.ctrl[1:0]); // R02
        end else begin
            match = |f_hit; // R02
        end
        crit = {pkt_err_i, f_hit, 1'b1};
    end

    // Counter increments from each counter's selected criteria.
    always_comb begin
        for (int i = 0; i < NS; i++) begin
            sb.inc[i] = pkt_valid_i && |(q.stat_sel[i] & crit); // R04
        end
    end
    assign sb.clr   = q.stat_clr;
    assign sb.level = q.stat_lvl;

    sat_counter_bank #(.N(NS), .W(SW)) u_bank (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .sb         (sb)
    );

    // Comparator thresholds picked from the two tables.
    always_comb begin
        for (int i = 0; i < CMP_N; i++) begin
            lat_thr[i]  = LAT_THR[q.thr[2*i +: 2]]; // R09
            pend_thr[i] = PEND_THR[q.thr[6 + 2*i +: 2]]; // R11
        end
        lat_now = sat_inc(q.lat); // R10
    end

    // Read data for the addressed register.
    always_comb begin
        rd_val = REG_RST;
        case (reg_addr_i)
            OFS_CTRL:      rd_val = 32'(q.ctrl);
            OFS_F0_BASE:   rd_val = q.f_base[0];
            OFS_F0_MASK:   rd_val = q.f_mask[0];
            OFS_F0_BLOCK:  rd_val = 32'(q.f_block[0]);
            OFS_F1_BASE:   rd_val = q.f_base[1];
            OFS_F1_MASK:   rd_val = q.f_mask[1];
            OFS_F1_BLOCK:  rd_val = 32'(q.f_block[1]);
            OFS_STAT_SEL:  rd_val = 32'(q.stat_sel);
            OFS_THR:       rd_val = 32'(q.thr);
            OFS_INT_STAT:  rd_val = 32'(q.int_st); // R03
            OFS_INT_MASK:  rd_val = 32'(q.int_msk);
            OFS_INFO:      rd_val = {16'h0, PROBE_ID, 3'h0,
                                     q.busy, q.pend, 4'h0};
            default: begin
                // Only word-aligned addresses reach a register.
                if (reg_addr_i[1:0] != 2'b00) begin
                    rd_val = REG_RST;
                end else if (reg_addr_i[7:4] == OFS_STAT_CNT[7:4]) begin
                    rd_val = 32'(sb.count[reg_addr_i[3:2]]);
                end else if (reg_addr_i[7:4] == OFS_STAT_LVL[7:4]) begin
                    rd_val = 32'(q.stat_lvl[reg_addr_i[3:2]]);
                end else if (reg_addr_i >= OFS_HIST
                             && reg_addr_i < OFS_INT_STAT) begin
                    rd_val = 32'(q.hist[2'(reg_addr_i[4:2] - 3'd1)]);
                end
            end
        endcase
    end

    assign wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;

    // Next state: registers, trace, alarms, transaction probe.
    always_comb begin
        logic [INT_W-1:0] ev;
        logic [1:0]       idx;
        d          = q;
        ev         = '0;
        idx        = 2'd0;
        d.stat_clr = wr_ctrl && reg_wdata_i[CTRL_CLEAR];
        d.rdata    = reg_rd_i ? rd_val : REG_RST;
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_CTRL:     d.ctrl       = reg_wdata_i[CTRL_W-1:0];
                OFS_F0_BASE:  d.f_base[0]  = reg_wdata_i;
                OFS_F0_MASK:  d.f_mask[0]  = reg_wdata_i;
                OFS_F0_BLOCK: d.f_block[0] = reg_wdata_i[15:0];
                OFS_F1_BASE:  d.f_base[1]  = reg_wdata_i;
                OFS_F1_MASK:  d.f_mask[1]  = reg_wdata_i;
                OFS_F1_BLOCK: d.f_block[1] = reg_wdata_i[15:0];
                OFS_STAT_SEL: d.stat_sel   = reg_wdata_i[15:0];
                OFS_THR:      d.thr        = reg_wdata_i[11:0];
                OFS_INT_MASK: d.int_msk    = reg_wdata_i[INT_W-1:0];
                default: begin
                    if (reg_addr_i[7:4] == OFS_STAT_LVL[7:4]
                        && reg_addr_i[1:0] == 2'b00) begin
                        d.stat_lvl[reg_addr_i[3:2]] =
                            reg_wdata_i[SW-1:0];
                    end
                end
            endcase
        end
        // Trace forwarding with the probe identifier.
        d.tr_valid = pkt_valid_i && match
            && q.ctrl[CTRL_TRACE_EN]; // R01
        d.tr_addr  = pkt_addr_i;
        d.tr_opc   = pkt_opc_i;
        d.tr_id    = PROBE_ID; // R06
        // Events for the sticky status register.
        for (int k = 0; k < NF; k++) begin
            ev[INT_TRACE + k] = pkt_valid_i && f_hit[k]
                && q.ctrl[CTRL_F0_ALARM + k]; // R03
        end
        ev[INT_STAT +: NS] = sb.hit; // R05
        ev[INT_ERR +: 3]   = {err_firewall_i, err_target_i,
                              err_initiator_i}; // R13
        if (reg_wr_i && reg_addr_i == OFS_INT_STAT) begin
            d.int_st = q.int_st & ~reg_wdata_i[INT_W-1:0];
        end
        d.int_st = d.int_st | ev;
        d.irq    = |(d.int_st & d.int_msk); // R12
        // Outstanding request count, saturating at both ends.
        if (txn_req_i && !txn_resp_i && q.pend != '1) begin
            d.pend = q.pend + 4'd1; // R11
        end else if (txn_resp_i && !txn_req_i && q.pend != '0) begin
            d.pend = q.pend - 4'd1;
        end
        // Latency of one tracked request at a time.
        if (q.busy) begin
            d.lat = lat_now; // R10
        end
        if (q.busy && txn_resp_i) begin
            d.busy = 1'b0;
        end else if (!q.busy && txn_req_i && q.pend == '0) begin
            d.busy = 1'b1; // R10
            d.lat  = '0;
        end
        // Histogram update in the selected mode.
        if (q.ctrl[CTRL_PEND]) begin
            idx = bin_of(HIST_W'(q.pend), pend_thr); // R07
            if (txn_req_i) begin
                d.hist[idx] = sat_inc(q.hist[idx]); // R08
            end
        end else begin
            idx = bin_of(lat_now, lat_thr); // R07
            if (q.busy && txn_resp_i) begin
                d.hist[idx] = sat_inc(q.hist[idx]); // R08
            end
        end
        if (d.stat_clr) begin
            d.hist = '0;
        end
    end

    // State register.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign reg_rdata_o   = q.rdata;
    assign trace_valid_o = q.tr_valid;
    assign trace_addr_o  = q.tr_addr;
    assign trace_opc_o   = q.tr_opc;
    assign trace_id_o    = q.tr_id;
    assign irq_o         = q.irq;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_lat_start;
        !q.ctrl[CTRL_PEND] && !q.busy && txn_req_i && q.pend == '0;
    endsequence
    sequence s_quiet_3;
        !txn_resp_i [*3];
    endsequence

    AST_TRACE_FWD: assert property ( // R01
        pkt_valid_i && match && q.ctrl[CTRL_TRACE_EN]
        |=> trace_valid_o && trace_addr_o == $past(pkt_addr_i))
        else $error("Matching packet was not traced.");
    AST_TRACE_ID: assert property ( // R06
        trace_valid_o |-> trace_id_o == PROBE_ID)
        else $error("Trace output lacks the probe identifier.");
    AST_FILT_AND: assert property ( // R02
        pkt_valid_i && q.ctrl[CTRL_COMBINE] && q.ctrl[CTRL_F0_EN]
        && !f_hit[0] |=> !trace_valid_o)
        else $error("Combined filters traced a partial match.");
    AST_TRACE_ALARM: assert property ( // R03
        pkt_valid_i && f_hit[0] && q.ctrl[CTRL_F0_ALARM]
        |=> q.int_st[INT_TRACE])
        else $error("Trace alarm was not raised.");
    AST_STAT_ALARM: assert property ( // R05
        sb.hit[0] |=> q.int_st[INT_STAT])
        else $error("Statistics alarm was not raised.");
    AST_IRQ: assert property ( // R12
        irq_o == |(q.int_st & q.int_msk))
        else $error("Interrupt does not follow unmasked status.");
    AST_ERR_LOG: assert property ( // R13
        err_target_i ##1 !$past(rst_i) |-> q.int_st[INT_ERR + 1])
        else $error("Target error was not recorded.");
    AST_LAT_COUNT: assert property ( // R10
        s_lat_start ##1 s_quiet_3 |=> q.lat == 10'd3 && q.busy)
        else $error("Latency count is off.");
    AST_PEND_UP: assert property ( // R11
        txn_req_i && !txn_resp_i && q.pend != '1
        |=> q.pend == $past(q.pend) + 4'd1)
        else $error("Pending count did not rise.");

    // Further checks on counts, tracing, alarms and errors.
    AST_PEND_DOWN: assert property ( // R11
        txn_resp_i && !txn_req_i && q.pend != '0
        |=> q.pend == $past(q.pend) - 4'd1)
        else $error("Pending count did not fall.");

    AST_BUSY_END: assert property ( // R10
        q.busy && txn_resp_i |=> !q.busy)
        else $error("Response did not end the count.");

    AST_TRACE_OFF: assert property ( // R01
        !q.ctrl[CTRL_TRACE_EN] |=> !trace_valid_o)
        else $error("Traced while tracing was off.");

    AST_F1_ALARM: assert property ( // R03
        pkt_valid_i && f_hit[1] && q.ctrl[CTRL_F0_ALARM + 1]
        |=> q.int_st[INT_TRACE + 1])
        else $error("Second filter alarm not raised.");

    AST_INIT_LOG: assert property ( // R13
        err_initiator_i |=> q.int_st[INT_ERR])
        else $error("Initiator error not recorded.");

    AST_FW_LOG: assert property ( // R13
        err_firewall_i |=> q.int_st[INT_ERR + 2])
        else $error("Firewall error not recorded.");
endmodule

/* test/probe_link_partner.sv */
`timescale 1ns/1ps
// Far side of the probe: answers transactions after a set delay and
// counts trace beats like the trace bus observer.
module probe_link_partner (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        txn_req_i,
    input  wire logic [10:0] resp_delay_i,
    output logic             txn_resp_o,
    input  wire logic        trace_valid_i,
    output logic [15:0]      trace_beats_o
);
    logic [10:0] wait_q;

    // Delay 0 leaves a request unanswered; 2 or more answers that many
    // cycles after the request was taken.
    always_ff @(posedge core_clk_i) begin
        txn_resp_o <= 1'b0;
        if (rst_i) begin
            wait_q        <= '0;
            trace_beats_o <= '0;
        end else begin
            if (txn_req_i) begin
                wait_q <= resp_delay_i;
            end else if (wait_q != 11'h000) begin
                wait_q     <= wait_q - 11'h001;
                txn_resp_o <= (wait_q == 11'h002);
            end
            if (trace_valid_i) begin
                trace_beats_o <= trace_beats_o + 16'h0001;
            end
        end
    end
endmodule

/* test/interconnect_observation_probes_tb.sv */
`timescale 1ns/1ps
module interconnect_observation_probes_tb;
    import obs_probe_pkg::*;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [31:0] addr;
        logic [3:0]  opc;
        logic        hit;
    } pkt_row_s;

    logic        core_clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        pkt_valid;
    logic [31:0] pkt_addr;
    logic [3:0]  pkt_opc;
    logic        pkt_err;
    logic        txn_req;
    logic        txn_resp;
    logic [10:0] resp_delay;
    logic        err_init;
    logic        err_tgt;
    logic        err_fw;
    logic        trace_valid;
    logic [31:0] trace_addr;
    logic [3:0]  trace_opc;
    logic [3:0]  trace_id;
    logic        irq;
    logic [15:0] beats;
    int          error_cnt;
    int          total_checks;
    // Filter 0 blocks opcode 2; filter 1 only looks at address bits 15:12.
    pkt_row_s    rows [8] = '{
        '{8'h21, 32'h0000_1234, 4'h1, 1'b1},
        '{8'h21, 32'h0000_2234, 4'h1, 1'b0},
        '{8'h21, 32'h0000_1234, 4'h2, 1'b0},
        '{8'h22, 32'h0001_1234, 4'h2, 1'b1},
        '{8'h23, 32'h0001_1234, 4'h1, 1'b1},
        '{8'h33, 32'h0001_1234, 4'h1, 1'b0},
        '{8'h33, 32'h0000_1234, 4'h1, 1'b1},
        '{8'h03, 32'h0000_1234, 4'h1, 1'b0}};
    logic [31:0] exp_cnt [4] = '{32'h3, 32'h2, 32'h1, 32'h2};
    logic [31:0] exp_lat [4] = '{32'h1, 32'h1, 32'h0, 32'h1};
    logic [31:0] exp_pnd [4] = '{32'h2, 32'h2, 32'h1, 32'h0};

    interconnect_observation_probes #(.PROBE_ID(ID_BRIDGE)) i_dut (
        .core_clk_i(core_clk), .rst_i(rst), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .pkt_valid_i(pkt_valid),
        .pkt_addr_i(pkt_addr), .pkt_opc_i(pkt_opc), .pkt_err_i(pkt_err),
        .txn_req_i(txn_req), .txn_resp_i(txn_resp),
        .err_initiator_i(err_init), .err_target_i(err_tgt),
        .err_firewall_i(err_fw), .trace_valid_o(trace_valid),
        .trace_addr_o(trace_addr), .trace_opc_o(trace_opc),
        .trace_id_o(trace_id), .irq_o(irq));

    probe_link_partner i_partner (
        .core_clk_i(core_clk), .rst_i(rst), .txn_req_i(txn_req),
        .resp_delay_i(resp_delay), .txn_resp_o(txn_resp),
        .trace_valid_i(trace_valid), .trace_beats_o(beats));

    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One-cycle register write strobe.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is only valid in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask

    // One packet on the link; returns in the cycle its trace appears.
    task automatic pkt(input logic [31:0] a, input logic [3:0] o,
                       input logic e);
        @(posedge core_clk);
        pkt_valid <= 1'b1;
        pkt_addr  <= a;
        pkt_opc   <= o;
        pkt_err   <= e;
        @(posedge core_clk);
        pkt_valid <= 1'b0;
        #1;
    endtask

    // One timed transaction; waits until its bin has been updated.
    task automatic txn(input logic [10:0] d);
        @(posedge core_clk);
        resp_delay <= d;
        txn_req    <= 1'b1;
        @(posedge core_clk);
        txn_req <= 1'b0;
        repeat (int'(d) + 2) @(posedge core_clk);
    endtask

    task automatic results;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run of about 66k cycles.
    initial begin
        #900_000;
        error_cnt++;
        results();
    end

    // Main sequence.
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, pkt_valid, pkt_addr} = '0;
        {pkt_opc, pkt_err, txn_req, resp_delay} = '0;
        {err_init, err_tgt, err_fw} = '0;
        error_cnt    = 0;
        total_checks = 0;
        rst          = 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("trace id", {28'h0, ID_BRIDGE}, {28'h0, trace_id});
        rd(OFS_INFO, {16'h0, ID_BRIDGE, 12'h000}, "info");
        rd(OFS_CTRL, REG_RST, "ctrl reset");
        wr(OFS_F0_BASE, 32'h0000_1000);
        wr(OFS_F0_MASK, 32'hffff_f000);
        wr(OFS_F0_BLOCK, 32'h0000_0004);
        wr(OFS_F1_BASE, 32'h0000_1000);
        wr(OFS_F1_MASK, 32'h0000_f000);
        foreach (rows[i]) begin
            wr(OFS_CTRL, {24'h0, rows[i].ctrl});
            pkt(rows[i].addr, rows[i].opc, 1'b0);
            check("trace valid", {31'h0, rows[i].hit},
                  {31'h0, trace_valid});
            if (rows[i].hit) begin
                check("trace addr", rows[i].addr, trace_addr);
                check("trace opc", 32'(rows[i].opc), 32'(trace_opc));
            end
        end
        check("trace beats", 32'h4, {16'h0, beats});
        // Alarms on both filters with tracing off.
        wr(OFS_INT_MASK, 32'h1);
        wr(OFS_CTRL, 32'h0f);
        pkt(32'h0000_1234, 4'h1, 1'b0);
        check("irq alarm", 32'h1, {31'h0, irq});
        check("no trace", 32'h0, {31'h0, trace_valid});
        rd(OFS_INT_STAT, 32'h3, "trace alarm");
        wr(OFS_INT_STAT, 32'h3);
        rd(OFS_INT_STAT, 32'h0, "alarm cleared");
        check("irq cleared", 32'h0, {31'h0, irq});
        // Statistics: any, filter 0, error, filter 1 criteria.
        wr(OFS_CTRL, 32'h83);
        wr(OFS_STAT_SEL, 32'h4821);
        wr(OFS_STAT_LVL, 32'h3);
        wr(OFS_INT_MASK, 32'h3c);
        pkt(32'h0000_1234, 4'h1, 1'b0);
        pkt(32'h0000_2234, 4'h1, 1'b1);
        pkt(32'h0000_1234, 4'h1, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        check("irq stat", 32'h1, {31'h0, irq});
        for (int i = 0; i < 4; i++) begin
            rd(OFS_STAT_CNT + 8'(4 * i), exp_cnt[i], "stat count");
        end
        rd(OFS_INT_STAT, 32'h4, "stat alarm");
        wr(OFS_STAT_CNT, 32'h55);
        rd(OFS_STAT_CNT, 32'h3, "count read only");
        // Back-to-back packets drive counter 0 past its top.
        @(posedge core_clk);
        pkt_valid <= 1'b1;
        pkt_addr  <= 32'h0000_2234;
        pkt_err   <= 1'b0;
        repeat (65540) @(posedge core_clk);
        pkt_valid <= 1'b0;
        rd(OFS_STAT_CNT, 32'hffff, "saturated");
        rd(OFS_STAT_CNT + 8'h4, 32'h2, "other count");
        // Latency histogram with thresholds 64, 128, 256.
        wr(OFS_INT_STAT, 32'h1ff);
        wr(OFS_THR, 32'h24);
        wr(OFS_CTRL, 32'h80);
        txn(11'd4);
        txn(11'd64);
        txn(11'd300);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_HIST + 8'(4 * i), exp_lat[i], "latency bin");
        end
        // Pending histogram with thresholds 2, 4, 8; no answers.
        wr(OFS_THR, 32'h900);
        wr(OFS_CTRL, 32'hc0);
        @(posedge core_clk);
        resp_delay <= 11'd0;
        txn_req    <= 1'b1;
        repeat (5) @(posedge core_clk);
        txn_req <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(OFS_HIST + 8'(4 * i), exp_pnd[i], "pending bin");
        end
        rd(OFS_INFO, {16'h0, ID_BRIDGE, 12'h150}, "pending");
        // Error events in successive cycles.
        wr(OFS_INT_MASK, 32'h1c0);
        @(posedge core_clk);
        err_init <= 1'b1;
        @(posedge core_clk);
        err_init <= 1'b0;
        err_tgt  <= 1'b1;
        @(posedge core_clk);
        err_tgt <= 1'b0;
        err_fw  <= 1'b1;
        @(posedge core_clk);
        err_fw <= 1'b0;
        #1;
        check("irq error", 32'h1, {31'h0, irq});
        rd(OFS_INT_STAT, 32'h1c0, "error log");
        wr(OFS_INT_MASK, 32'h0);
        #1;
        check("irq masked", 32'h0, {31'h0, irq});
        wr(8'h60, 32'hffff_ffff);
        rd(8'h60, 32'h0, "unmapped");
        // Reset in mid-run returns everything but the probe identifier to zero.
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(OFS_INT_STAT, 32'h0, "status after reset");
        rd(OFS_INFO, {16'h0, ID_BRIDGE, 12'h000}, "info after reset");
        results();
    end
endmodule
